// file: logic/reference_control_pkg.sv
// Constants for the voltage reference control register block
package reference_control_pkg;
    localparam logic [7:0] reference_control_addr = 8'hd1;
    localparam logic [7:0] reference_control_reset = 8'h00;
    localparam int reference_source_select_bit = 3;
    localparam int temp_sensor_enable_bit = 2;
    localparam int bias_generator_enable_bit = 1;
    localparam logic [7:0] reference_control_write_mask = 8'h0e;
    localparam logic [3:0] mux_temp_sensor_code = 4'h8;
    localparam int conversion_min_sar_clocks = 11;
endpackage

// file: logic/voltage_reference_control.sv
// Reference control register with bias force and sensor mux routing
//
// How it works
// [R1] Bit 3 clear routes the external reference pin, set routes the supply.
// [R2] Bit 2 switches the temperature sensor on when set.
// [R3] Bit 1 switches the bias generator on when set.
// [R4] Bias enable is forced high while converter, sensor or oscillator run.
// [R5] A stored one in bit 1 turns bias on with no dependent peripheral.
// [R6] Software sets the bias bit before using the converter.
// [R7] Bit 0 reads zero and ignores writes.
// [R8] Bits 7 to 4 read zero and ignore writes.
// [R9] Software sets up the external reference pin as analog and skipped.
// [R10] The sensor sits on the highest positive mux selection.
// [R11] A conversion lasts at least 11 conversion clock cycles.
// [R12] Positive mux code 1000 connects the sensor to the converter input.
// [R13] Reset clears the register to all zeros.
`timescale 1ns/1ps
module voltage_reference_control
    import reference_control_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Special-function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_write,
    input wire logic sfr_read,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Dependent peripheral enables, same clock
    input wire logic converter_enable,
    input wire logic oscillator_enable,
    // Converter positive mux selection, same clock
    input wire logic [3:0] positive_mux_select,
    // Analog controls
    output logic reference_source_select,
    output logic temp_sensor_enable,
    output logic bias_generator_enable,
    output logic temp_sensor_to_converter,
    // Minimum conversion length for the sequencer
    output logic [3:0] conversion_min_clocks
);
    typedef struct packed
    {
        logic [7:0] reg_value;
        logic [7:0] rdata;
        logic hit;
        logic ref_sel;
        logic temp_en;
        logic bias_en;
        logic temp_route;
        logic [3:0] min_clocks;
    } state_t;

    state_t state;
    state_t next_state;

    function automatic logic addr_match(input logic [7:0] a);
        addr_match = (a == reference_control_addr);
    endfunction

    always_comb
    begin
        next_state = state;
        next_state.hit = 1'b0;
        next_state.rdata = 8'h00;
        // [R7] [R8] masked store
        if (sfr_write && addr_match(sfr_addr))
        begin
            next_state.reg_value = sfr_wdata & reference_control_write_mask;
        end
        // [R7] [R8] unused bits read zero
        if (sfr_read && addr_match(sfr_addr))
        begin
            next_state.rdata = state.reg_value & reference_control_write_mask;
            next_state.hit = 1'b1;
        end
        // [R1] reference source
        next_state.ref_sel = next_state.reg_value[reference_source_select_bit];
        // [R2] sensor enable
        next_state.temp_en = next_state.reg_value[temp_sensor_enable_bit];
        // [R3] [R4] [R5] bias force or manual
        next_state.bias_en = next_state.reg_value[bias_generator_enable_bit]
            | converter_enable | oscillator_enable
            | next_state.reg_value[temp_sensor_enable_bit];
        // [R10] [R12] sensor on top mux code
        next_state.temp_route = (positive_mux_select == mux_temp_sensor_code);
        // [R11] conversion floor
        next_state.min_clocks = 4'(conversion_min_sar_clocks);
    end

    always_ff @(posedge clk)
    begin
        // [R13] clear on reset
        if (!resetn)
        begin
            state <= '0;
            state.reg_value <= reference_control_reset;
            state.min_clocks <= 4'(conversion_min_sar_clocks);
        end
        else
        begin
            state <= next_state;
        end
    end

    assign sfr_rdata = state.rdata;
    assign sfr_hit = state.hit;
    assign reference_source_select = state.ref_sel;
    assign temp_sensor_enable = state.temp_en;
    assign bias_generator_enable = state.bias_en;
    assign temp_sensor_to_converter = state.temp_route;
    assign conversion_min_clocks = state.min_clocks;
endmodule

// file: dv/vref_monitor.sv
// Assertion checker, reference control register
`timescale 1ns/1ps
module vref_monitor (input wire logic clk, resetn, sfr_write, sfr_hit,
    converter_enable, oscillator_enable, reference_source_select,
    temp_sensor_enable, bias_generator_enable, temp_sensor_to_converter,
    input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
    input wire logic [3:0] positive_mux_select);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence wr_s; sfr_write && sfr_addr == 8'hd1; endsequence
    ref_sel_a: assert property (wr_s |=> reference_source_select ==
        $past(sfr_wdata[3])) else $error("ref select");
    sen_en_a: assert property (wr_s |=> temp_sensor_enable ==
        $past(sfr_wdata[2])) else $error("sensor enable");
    man_bias_a: assert property (wr_s ##0 sfr_wdata[1] |=>
        bias_generator_enable) else $error("manual bias");
    frc_a: assert property (converter_enable || oscillator_enable |=>
        bias_generator_enable) else $error("forced bias");
    sen_bias_a: assert property (temp_sensor_enable [*2] |->
        bias_generator_enable) else $error("sensor bias");
    bit0_a: assert property (sfr_hit |-> !sfr_rdata[0])
        else $error("bit0");
    upper_a: assert property (sfr_hit |-> !sfr_rdata[7:4])
        else $error("upper bits");
    mux_a: assert property (positive_mux_select == 4'h8 |=>
        temp_sensor_to_converter) else $error("mux");
endmodule

// file: dv/tb.sv
// Bench for the reference control register
`timescale 1ns/1ps
module tb;
    logic clk = 0, resetn = 0, sfr_write = 0, sfr_read = 0, sfr_hit;
    logic converter_enable = 0, oscillator_enable = 0;
    logic [7:0] sfr_addr = 8'hd1, sfr_wdata = 8'h00, sfr_rdata;
    logic [3:0] positive_mux_select = 4'h0, conversion_min_clocks;
    logic reference_source_select, temp_sensor_enable;
    logic bias_generator_enable, temp_sensor_to_converter;
    int fails = 0, compares = 0;
    // Row: wdata, converter, oscillator, mux, expected controls
    // row 0 sets the bias bit with the converter and oscillator idle
    // pin setup for the external reference is outside this block
    logic [17:0] rows [8] = '{18'h3fc0e, 18'h00081, 18'h00892,
        18'h00202, 18'h00172, 18'h01006, 18'h02008, 18'h3c400};
    wire [4:0] o = {sfr_hit, reference_source_select, temp_sensor_enable,
        bias_generator_enable, temp_sensor_to_converter};
    voltage_reference_control DUT (.*);
    always #10 clk = ~clk;
    task chk(string n, logic [7:0] s, e);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s exp %h saw %h", n, e, s);
        end
    endtask
    task acc(logic [7:0] a, w);
        sfr_addr = a;
        sfr_wdata = w;
        sfr_write = 1;
        @(negedge clk) sfr_write = 0;
        sfr_read = 1;
        @(negedge clk) sfr_read = 0;
    endtask
    task test_done;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge clk);
        chk("reset", {o[3:0], conversion_min_clocks}, 8'h0b);
        resetn = 1;
        foreach (rows[i])
        begin
            {converter_enable, oscillator_enable, positive_mux_select} =
                rows[i][9:4];
            acc(8'hd1, rows[i][17:10]);
            chk("controls", o, {1'h1, rows[i][3:0]});
            chk("rdata", sfr_rdata, rows[i][17:10] & 8'h0e);
            $display("row %0d done", i);
        end
        acc(8'hd1, 8'hff);
        acc(8'hd0, 8'h00);
        chk("unmapped", {sfr_rdata[2:0], o}, 8'h0e);
        resetn = 0;
        @(negedge clk) resetn = 1;
        chk("rerun", o, 8'h00);
        $display("reset cases done");
        test_done;
    end
    initial
    begin
        #20000;
        fails++;
        test_done;
    end
endmodule
bind voltage_reference_control vref_monitor mon (.*);
